/* rtl/sru_pkg.sv */
// constants of the status reporting unit: bit positions, commands, reset values
package sru_pkg;
  // standard event bit positions
  localparam int STD_OPC_BIT = 0;
  localparam int STD_QYE_BIT = 2;
  localparam int STD_DDE_BIT = 3;
  localparam int STD_EXE_BIT = 4;
  localparam int STD_CME_BIT = 5;
  localparam int STD_PON_BIT = 7;
  localparam logic [7:0] STD_VALID = 8'hBD;
  // questionable data bit positions
  localparam int QUES_VOLT_BIT = 0;
  localparam int QUES_CURR_BIT = 1;
  localparam int QUES_OHMS_BIT = 9;
  localparam int QUES_LOLIM_BIT = 11;
  localparam int QUES_HILIM_BIT = 12;
  localparam logic [15:0] QUES_VALID = 16'h1A03;
  // status byte bit positions
  localparam int STB_QUES_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_STD_BIT = 5;
  localparam int STB_RQS_BIT = 6;
  // reset values
  localparam logic [7:0] STD_RESET = 8'h80;
  localparam logic [15:0] QUES_RESET = 16'h0000;
  localparam logic [7:0] ESE_RESET = 8'h00;
  localparam logic [15:0] QMASK_RESET = 16'h0000;
  localparam logic [7:0] SRE_CLEAR = 8'h00;
  // error queue
  localparam int ERR_DEPTH = 20;
  localparam int ERR_CHARS = 80;
  localparam int ERR_WIDTH = 16;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  // host command codes
  typedef enum logic [3:0] {
    SRU_OP_ESR_Q   = 4'h0,
    SRU_OP_QEVT_Q  = 4'h1,
    SRU_OP_ESE_W   = 4'h2,
    SRU_OP_ESE_Q   = 4'h3,
    SRU_OP_QENA_W  = 4'h4,
    SRU_OP_QENA_Q  = 4'h5,
    SRU_OP_SRE_W   = 4'h6,
    SRU_OP_SRE_Q   = 4'h7,
    SRU_OP_STB_Q   = 4'h8,
    SRU_OP_CLS     = 4'h9,
    SRU_OP_PRESET  = 4'hA,
    SRU_OP_RST     = 4'hB,
    SRU_OP_DCL     = 4'hC,
    SRU_OP_ERR_Q   = 4'hD
  } sru_op_t;
endpackage

/* rtl/sru_status_unit.sv */
// status reporting unit: event latches, masks, status byte, service request, error queue
`timescale 1ns/100ps
module sru_status_unit #(
  parameter int ERR_DEPTH = sru_pkg::ERR_DEPTH,
  parameter int ERR_WIDTH = sru_pkg::ERR_WIDTH
) (
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic [7:0]           stdEvtIn,
  input  wire logic [15:0]          quesEvtIn,
  input  wire logic                 outBufNotEmpty,
  input  wire logic                 pscFlag,
  input  wire logic                 errPush,
  input  wire logic [ERR_WIDTH-1:0] errCode,
  input  wire logic                 cmdValid,
  input  wire logic [3:0]           cmdOp,
  input  wire logic [15:0]          cmdData,
  input  wire logic                 serialPoll,
  output logic                      rspValid,
  output logic [15:0]               rspData,
  output logic                      spollValid,
  output logic [7:0]                spollData,
  output logic                      srqLine,
  output logic                      errFull
);
  localparam int PW = $clog2(ERR_DEPTH);
  // the request bit never feeds its own cause nor the service mask
  localparam logic [7:0] RQS_ONLY = 8'(1 << sru_pkg::STB_RQS_BIT);

  // parameters the queue logic cannot serve
  if (ERR_DEPTH < 2 || ERR_WIDTH < 1 || ERR_WIDTH > 16) begin : g_badParam
    $error("sru_status_unit: unsupported queue parameters");
  end

  logic [7:0]           stdReg, stdNext;
  logic [15:0]          quesReg, quesNext;
  logic [7:0]           eseReg, eseNext;
  logic [15:0]          qmaskReg, qmaskNext;
  logic [7:0]           sreReg, sreNext;
  logic                 rqsReg, rqsNext;
  logic                 svcPrevReg, svcPrevNext;
  logic                 rspValidNext, spollValidNext, srqNext;
  logic [15:0]          rspDataNext;
  logic [7:0]           spollDataNext;
  logic [ERR_WIDTH-1:0] errMem [ERR_DEPTH];
  logic [PW-1:0]        wrPtrReg, wrPtrNext, rdPtrReg, rdPtrNext;
  logic [PW:0]          cntReg, cntNext;
  logic                 errFullNext;
  logic                 quesSum, stdSum, svcAny, doPush, doPop;
  logic [7:0]           stbByte;
  logic                 isCmd [16];

  // one-hot decode of the host command
  for (genvar i = 0; i < 16; i++) begin : g_dec
    assign isCmd[i] = cmdValid && (cmdOp == 4'(i));
  end

  // summaries from current contents, so mask edits act at once
  assign quesSum = |(quesReg & qmaskReg);
  assign stdSum  = |(stdReg & eseReg);
  // status byte assembly, unused bits stay zero
  always_comb begin
    stbByte = 8'h00;
    stbByte[sru_pkg::STB_QUES_BIT] = quesSum;
    stbByte[sru_pkg::STB_MAV_BIT]  = outBufNotEmpty;
    stbByte[sru_pkg::STB_STD_BIT]  = stdSum;
    stbByte[sru_pkg::STB_RQS_BIT]  = rqsReg;
  end
  // only summaries enabled in the service mask can request service
  assign svcAny = |(stbByte & sreReg & ~RQS_ONLY);

  // next state of event latches and masks
  always_comb begin
    // latch new conditions on their defined bits only
    stdNext  = stdReg | (stdEvtIn & sru_pkg::STD_VALID);
    quesNext = quesReg | (quesEvtIn & sru_pkg::QUES_VALID);
    // a read or clear-status empties the latch, arrivals this cycle survive
    if (isCmd[sru_pkg::SRU_OP_ESR_Q] || isCmd[sru_pkg::SRU_OP_CLS]) begin
      stdNext = stdEvtIn & sru_pkg::STD_VALID;
    end
    if (isCmd[sru_pkg::SRU_OP_QEVT_Q] || isCmd[sru_pkg::SRU_OP_CLS]) begin
      quesNext = quesEvtIn & sru_pkg::QUES_VALID;
    end
    // reset and device clear fall through without touching the latches
    // outside reset, masks change only on their own writes, and the questionable mask also on preset
    eseNext   = isCmd[sru_pkg::SRU_OP_ESE_W] ? (cmdData[7:0] & sru_pkg::STD_VALID) : eseReg;
    qmaskNext = isCmd[sru_pkg::SRU_OP_QENA_W] ? (cmdData & sru_pkg::QUES_VALID) : qmaskReg;
    if (isCmd[sru_pkg::SRU_OP_PRESET]) begin
      qmaskNext = sru_pkg::QMASK_RESET;
    end
    // writing zero clears; power-up clears only with the flag set
    sreNext = sreReg;
    if (isCmd[sru_pkg::SRU_OP_SRE_W] && !sys_rst) begin
      sreNext = cmdData[7:0] & ~RQS_ONLY;
    end
    if (sys_rst && pscFlag) begin
      sreNext = sru_pkg::SRE_CLEAR;
    end
  end

  // registers of latches and masks; the service mask survives reset unless flagged
  always_ff @(posedge mclk) begin
    sreReg <= sreNext;
    if (sys_rst) begin
      stdReg   <= sru_pkg::STD_RESET;
      quesReg  <= sru_pkg::QUES_RESET;
      eseReg   <= sru_pkg::ESE_RESET;
      qmaskReg <= sru_pkg::QMASK_RESET;
    end else begin
      stdReg   <= stdNext;
      quesReg  <= quesNext;
      eseReg   <= eseNext;
      qmaskReg <= qmaskNext;
    end
  end

  // request service and poll next state
  always_comb begin
    svcPrevNext = svcAny;
    rqsNext = rqsReg;
    // a poll clears only the request bit
    if (serialPoll) begin
      rqsNext = 1'b0;
    end
    // cleared also when its cause goes away, e.g. the event register was read
    if (!svcAny) begin
      rqsNext = 1'b0;
    end
    // a new enabled summary raises the request; set wins over a poll
    if (svcAny && !svcPrevReg) begin
      rqsNext = 1'b1;
    end
    srqNext = rqsNext;
    spollValidNext = serialPoll;
    spollDataNext  = serialPoll ? stbByte : spollData;
  end

  // registers of request service and poll answer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rqsReg     <= 1'b0;
      svcPrevReg <= 1'b0;
      srqLine    <= 1'b0;
      spollValid <= 1'b0;
      spollData  <= 8'h00;
    end else begin
      rqsReg     <= rqsNext;
      svcPrevReg <= svcPrevNext;
      srqLine    <= srqNext;
      spollValid <= spollValidNext;
      spollData  <= spollDataNext;
    end
  end

  // error queue pointers; a push into a full queue is dropped
  always_comb begin
    doPush    = errPush && (cntReg != ERR_DEPTH[PW:0]);
    doPop     = isCmd[sru_pkg::SRU_OP_ERR_Q] && (cntReg != '0);
    wrPtrNext = doPush ? ((wrPtrReg == PW'(ERR_DEPTH - 1)) ? '0 : wrPtrReg + 1'b1) : wrPtrReg;
    rdPtrNext = doPop ? ((rdPtrReg == PW'(ERR_DEPTH - 1)) ? '0 : rdPtrReg + 1'b1) : rdPtrReg;
    cntNext   = cntReg + {{PW{1'b0}}, doPush} - {{PW{1'b0}}, doPop};
    errFullNext = (cntNext == ERR_DEPTH[PW:0]);
  end

  // queue storage and pointers; the message text itself lives elsewhere
  always_ff @(posedge mclk) begin
    if (doPush) begin
      errMem[wrPtrReg] <= errCode;
    end
    if (sys_rst) begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
      cntReg   <= '0;
      errFull  <= 1'b0;
    end else begin
      wrPtrReg <= wrPtrNext;
      rdPtrReg <= rdPtrNext;
      cntReg   <= cntNext;
      errFull  <= errFullNext;
    end
  end

  // query answers: one word, the weighted sum of the bits or the oldest error code, one cycle later
  always_comb begin
    rspValidNext = 1'b0;
    rspDataNext  = 16'h0000;
    if (cmdValid) begin
      unique case (cmdOp)
        // value before the clear is returned
        sru_pkg::SRU_OP_ESR_Q:  begin rspValidNext = 1'b1; rspDataNext = {8'h00, stdReg}; end
        sru_pkg::SRU_OP_QEVT_Q: begin rspValidNext = 1'b1; rspDataNext = quesReg; end
        sru_pkg::SRU_OP_ESE_Q:  begin rspValidNext = 1'b1; rspDataNext = {8'h00, eseReg}; end
        sru_pkg::SRU_OP_QENA_Q: begin rspValidNext = 1'b1; rspDataNext = qmaskReg; end
        sru_pkg::SRU_OP_SRE_Q:  begin rspValidNext = 1'b1; rspDataNext = {8'h00, sreReg}; end
        sru_pkg::SRU_OP_STB_Q:  begin rspValidNext = 1'b1; rspDataNext = {8'h00, stbByte}; end
        sru_pkg::SRU_OP_ERR_Q: begin
          rspValidNext = 1'b1;
          rspDataNext  = (cntReg != '0) ? 16'(errMem[rdPtrReg]) : sru_pkg::ERR_NONE;
        end
        default: ;
      endcase
    end
  end

  // response register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rspValid <= 1'b0;
      rspData  <= 16'h0000;
    end else begin
      rspValid <= rspValidNext;
      rspData  <= rspDataNext;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_latch_hold: assert property (
    !isCmd[sru_pkg::SRU_OP_ESR_Q] && !isCmd[sru_pkg::SRU_OP_CLS]
      |=> (stdReg & $past(stdReg)) == $past(stdReg))
    else $error("standard event bit dropped without a clear");
  a_read_clears: assert property (
    isCmd[sru_pkg::SRU_OP_QEVT_Q] |=> quesReg == ($past(quesEvtIn) & sru_pkg::QUES_VALID))
    else $error("questionable read did not clear the latch");
  a_reset_keeps: assert property (
    isCmd[sru_pkg::SRU_OP_RST] || isCmd[sru_pkg::SRU_OP_DCL]
      |=> (stdReg & $past(stdReg)) == $past(stdReg))
    else $error("reset command disturbed event bits");
  a_read_value: assert property (
    isCmd[sru_pkg::SRU_OP_ESR_Q] |=> rspValid && rspData == {8'h00, $past(stdReg)})
    else $error("event read returned wrong value");
  a_summary_or: assert property (
    serialPoll |=> spollData[sru_pkg::STB_QUES_BIT] == (|($past(quesReg) & $past(qmaskReg))))
    else $error("questionable summary mismatch");
  a_mask_read: assert property (
    isCmd[sru_pkg::SRU_OP_ESE_Q] |=> rspData == {8'h00, $past(eseReg)} && eseReg == $past(eseReg))
    else $error("mask read wrong or altered mask");
  a_cls_masks: assert property (
    isCmd[sru_pkg::SRU_OP_CLS] |=> eseReg == $past(eseReg) && qmaskReg == $past(qmaskReg))
    else $error("clear-status altered a mask");
  a_preset_zero: assert property (
    isCmd[sru_pkg::SRU_OP_PRESET] |=> qmaskReg == 16'h0000)
    else $error("preset left questionable mask set");
  a_poll_answer: assert property (
    serialPoll && !(svcAny && !svcPrevReg) |=> spollValid && spollData == $past(stbByte)
      && !rqsReg)
    else $error("serial poll answer or request clear wrong");
  a_unused_zero: assert property (
    (stdReg & ~sru_pkg::STD_VALID) == 8'h00 && (quesReg & ~sru_pkg::QUES_VALID) == 16'h0000)
    else $error("unused event bit set");
  a_srq_drive: assert property (
    svcAny && !svcPrevReg |=> srqLine && rqsReg)
    else $error("service request line not raised");
  a_ques_hold: assert property (
    !isCmd[sru_pkg::SRU_OP_QEVT_Q] && !isCmd[sru_pkg::SRU_OP_CLS]
      |=> (quesReg & $past(quesReg)) == $past(quesReg))
    else $error("questionable event bit dropped without a clear");
  a_stb_answer: assert property (
    isCmd[sru_pkg::SRU_OP_STB_Q] |=> rspValid && rspData == {8'h00, 1'b0, $past(rqsReg),
      (|($past(stdReg) & $past(eseReg))), $past(outBufNotEmpty),
      (|($past(quesReg) & $past(qmaskReg))), 3'b000})
    else $error("status byte query answer wrong");
  a_mav_poll: assert property (
    serialPoll |=> spollData[sru_pkg::STB_MAV_BIT] == $past(outBufNotEmpty))
    else $error("message bit lagged the output buffer");
  a_cls_summary: assert property (
    isCmd[sru_pkg::SRU_OP_CLS] && stdEvtIn == 8'h00 && quesEvtIn == 16'h0000
      |=> !stbByte[sru_pkg::STB_QUES_BIT] && !stbByte[sru_pkg::STB_STD_BIT])
    else $error("summary bit survived clear-status");
  a_sre_clear: assert property (
    disable iff (1'b0) sys_rst && pscFlag |=> sreReg == sru_pkg::SRE_CLEAR)
    else $error("service mask not cleared at power-up");
  a_sre_keep: assert property (
    disable iff (1'b0) sys_rst && !pscFlag |=> sreReg == $past(sreReg))
    else $error("service mask lost at power-up");
  a_full_drop: assert property (
    errPush && errFull && !cmdValid |=> errFull && wrPtrReg == $past(wrPtrReg))
    else $error("push into a full queue was not dropped");
  a_empty_none: assert property (
    isCmd[sru_pkg::SRU_OP_ERR_Q] && cntReg == '0
      |=> rspValid && rspData == sru_pkg::ERR_NONE)
    else $error("empty error queue answered a code");
endmodule // sru_status_unit

/* bench/sru_host_model.sv */
// host-side model of the bus controller: command, query and serial poll cycles
`timescale 1ns/100ps
module sru_host_model (
  input  wire logic        mclk,
  output logic             cmdValid,
  output logic [3:0]       cmdOp,
  output logic [15:0]      cmdData,
  output logic             serialPoll,
  input  wire logic        rspValid,
  input  wire logic [15:0] rspData,
  input  wire logic        spollValid,
  input  wire logic [7:0]  spollData
);
  // idle bus until the first command
  initial begin
    cmdValid = 1'b0;
    cmdOp = 4'h0;
    cmdData = 16'h0000;
    serialPoll = 1'b0;
  end

  // one-cycle command pulse, launched just after an edge
  task automatic send(input logic [3:0] op, input logic [15:0] data);
    @(posedge mclk);
    #1;
    cmdValid = 1'b1;
    cmdOp = op;
    cmdData = data;
    @(posedge mclk);
    #1;
    cmdValid = 1'b0;
  endtask

  // query; an answer that never comes leaves unknown, so the compare fails
  task automatic query(input logic [3:0] op, output logic [15:0] val);
    int n;
    val = 16'hXXXX;
    send(op, 16'h0000);
    for (n = 0; n < 3; n++) begin
      if (rspValid === 1'b1) begin
        val = rspData;
        break;
      end
      @(posedge mclk);
      #1;
    end
  endtask

  // serial poll, same bounded wait for the answer pulse
  task automatic poll(output logic [7:0] val);
    int n;
    val = 8'hXX;
    @(posedge mclk);
    #1;
    serialPoll = 1'b1;
    @(posedge mclk);
    #1;
    serialPoll = 1'b0;
    for (n = 0; n < 3; n++) begin
      if (spollValid === 1'b1) begin
        val = spollData;
        break;
      end
      @(posedge mclk);
      #1;
    end
  endtask

  task automatic srqSetup(input logic [7:0] ese, input logic [7:0] sre);
    send(sru_pkg::SRU_OP_CLS, 16'h0000);
    send(sru_pkg::SRU_OP_ESE_W, {8'h00, ese});
    send(sru_pkg::SRU_OP_SRE_W, {8'h00, sre});
  endtask
endmodule // sru_host_model

/* bench/test_status_reporting_unit.sv */
// self-checking testbench of the status reporting unit
`timescale 1ns/100ps
module test_status_reporting_unit;
  logic        mclk           = 1'b0;
  logic        sys_rst        = 1'b1;
  logic [7:0]  stdEvtIn       = 8'h00;
  logic [15:0] quesEvtIn      = 16'h0000;
  logic        outBufNotEmpty = 1'b0;
  logic        pscFlag        = 1'b1;
  logic        errPush        = 1'b0;
  logic [15:0] errCode        = 16'h0000;
  logic        cmdValid, serialPoll, rspValid, spollValid, srqLine, errFull;
  logic [3:0]  cmdOp;
  logic [15:0] cmdData, rspData;
  logic [7:0]  spollData, sp;
  int          errCount       = 0;
  int          nChecks        = 0;
  int          i;

  always #5 mclk = ~mclk;

  sru_status_unit dut (.mclk(mclk), .sys_rst(sys_rst), .stdEvtIn(stdEvtIn),
    .quesEvtIn(quesEvtIn), .outBufNotEmpty(outBufNotEmpty), .pscFlag(pscFlag),
    .errPush(errPush), .errCode(errCode), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdData(cmdData), .serialPoll(serialPoll), .rspValid(rspValid),
    .rspData(rspData), .spollValid(spollValid), .spollData(spollData),
    .srqLine(srqLine), .errFull(errFull));

  sru_host_model host (.mclk(mclk), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdData(cmdData), .serialPoll(serialPoll), .rspValid(rspValid),
    .rspData(rspData), .spollValid(spollValid), .spollData(spollData));

  // compare and count; unknown never matches
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic q(input logic [3:0] op, input logic [15:0] exp);
    logic [15:0] v;
    host.query(op, v);
    chk(v, exp);
  endtask

  // event conditions held for one cycle only, so latching is what we see
  task automatic ev(input logic [7:0] s, input logic [15:0] qd);
    @(posedge mclk);
    #1;
    stdEvtIn = s;
    quesEvtIn = qd;
    @(posedge mclk);
    #1;
    stdEvtIn = 8'h00;
    quesEvtIn = 16'h0000;
  endtask

  task automatic doReset(input logic psc);
    @(posedge mclk);
    #1;
    pscFlag = psc;
    sys_rst = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
  endtask

  task automatic push(input logic [15:0] c);
    @(posedge mclk);
    #1;
    errPush = 1'b1;
    errCode = c;
    @(posedge mclk);
    #1;
    errPush = 1'b0;
  endtask

  task automatic printVerdict;
    if (errCount == 0 && nChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    errCount++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    printVerdict;
  end

  // main sequence
  initial begin
    doReset(1'b1);
    q(sru_pkg::SRU_OP_ESR_Q, 16'h0080);
    q(sru_pkg::SRU_OP_ESR_Q, 16'h0000);
    q(sru_pkg::SRU_OP_SRE_Q, 16'h0000);
    // latched weighted sums, unused bits zero
    ev(8'hFF, 16'hFFFF);
    repeat (2) @(posedge mclk);
    q(sru_pkg::SRU_OP_ESR_Q, {8'h00, sru_pkg::STD_VALID});
    q(sru_pkg::SRU_OP_QEVT_Q, sru_pkg::QUES_VALID);
    host.send(sru_pkg::SRU_OP_ESE_W, 16'h0020);
    q(sru_pkg::SRU_OP_ESE_Q, 16'h0020);
    q(sru_pkg::SRU_OP_ESE_Q, 16'h0020);
    ev(8'h20, 16'h0000);
    q(sru_pkg::SRU_OP_STB_Q, 16'h0020);
    host.send(sru_pkg::SRU_OP_ESE_W, 16'h0000);
    q(sru_pkg::SRU_OP_STB_Q, 16'h0000);
    host.send(sru_pkg::SRU_OP_ESE_W, 16'h0020);
    q(sru_pkg::SRU_OP_STB_Q, 16'h0020);
    q(sru_pkg::SRU_OP_ESR_Q, 16'h0020);
    q(sru_pkg::SRU_OP_STB_Q, 16'h0000);
    host.send(sru_pkg::SRU_OP_QENA_W, 16'h0200);
    ev(8'h20, 16'h0200);
    q(sru_pkg::SRU_OP_STB_Q, 16'h0028);
    host.send(sru_pkg::SRU_OP_CLS, 16'h0000);
    q(sru_pkg::SRU_OP_STB_Q, 16'h0000);
    q(sru_pkg::SRU_OP_QENA_Q, 16'h0200);
    q(sru_pkg::SRU_OP_ESE_Q, 16'h0020);
    host.send(sru_pkg::SRU_OP_PRESET, 16'h0000);
    q(sru_pkg::SRU_OP_QENA_Q, 16'h0000);
    // reset command and device clear keep events
    ev(8'h08, 16'h1001);
    host.send(sru_pkg::SRU_OP_RST, 16'h0000);
    host.send(sru_pkg::SRU_OP_DCL, 16'h0000);
    q(sru_pkg::SRU_OP_ESR_Q, 16'h0008);
    q(sru_pkg::SRU_OP_QEVT_Q, 16'h1001);
    // message bit follows the output buffer
    outBufNotEmpty = 1'b1;
    q(sru_pkg::SRU_OP_STB_Q, 16'h0010);
    outBufNotEmpty = 1'b0;
    q(sru_pkg::SRU_OP_STB_Q, 16'h0000);
    host.srqSetup(8'h20, 8'h20);
    ev(8'h20, 16'h0000);
    for (i = 0; i < 6 && srqLine !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk({15'h0000, srqLine}, 16'h0001);
    host.poll(sp);
    chk({8'h00, sp}, 16'h0060);
    repeat (2) @(posedge mclk);
    chk({15'h0000, srqLine}, 16'h0000);
    q(sru_pkg::SRU_OP_STB_Q, 16'h0020);
    // power-on flag decides whether the service mask survives reset
    host.send(sru_pkg::SRU_OP_SRE_W, 16'h0008);
    doReset(1'b0);
    q(sru_pkg::SRU_OP_SRE_Q, 16'h0008);
    host.send(sru_pkg::SRU_OP_SRE_W, 16'h0000);
    q(sru_pkg::SRU_OP_SRE_Q, 16'h0000);
    host.send(sru_pkg::SRU_OP_SRE_W, 16'h0008);
    doReset(1'b1);
    q(sru_pkg::SRU_OP_SRE_Q, 16'h0000);
    // fill past depth, overflow dropped, drain in order
    for (i = 0; i <= sru_pkg::ERR_DEPTH; i++) push(16'(16'h0100 + i));
    chk({15'h0000, errFull}, 16'h0001);
    for (i = 0; i < sru_pkg::ERR_DEPTH; i++) q(sru_pkg::SRU_OP_ERR_Q, 16'(16'h0100 + i));
    q(sru_pkg::SRU_OP_ERR_Q, sru_pkg::ERR_NONE);
    chk({15'h0000, errFull}, 16'h0000);
    printVerdict;
  end
endmodule // test_status_reporting_unit
